//--- verification/hcse_cmd_status_regs_sva.sv
`timescale 1ns/1ns
module hcse_cmd_status_regs_sva
    import hcse_pkg::*;
#(
    parameter int RESET_HOLD_CYCLES = HCSE_SOFT_RST_MAX_CYC - HCSE_SOFT_RST_OVERHEAD
)
(
    input wire logic                   clk_i,
    input wire logic                   rst_b_i,
    input wire logic                   reg_valid_i,
    input wire logic [7:0]             reg_code_i,
    input wire logic [31:0]            reg_wdata_i,
    input wire logic [31:0]            reg_rdata_o,
    input wire logic                   reg_rdata_valid_o,
    input wire logic                   sched_overrun_i,
    input wire logic [HCSE_FLAG_W-1:0] controller_event_mask_i,
    input wire logic                   global_irq_gate_i,
    input wire logic                   irq_o,
    input wire logic                   soft_reset_active_o,
    input wire logic                   suspend_request_o,
    input wire logic                   soft_reset_done_o
);
    logic [31:0] run_cnt;
    wire         rd_take = reg_valid_i && (reg_code_i == HCSE_CODE_CMD_RD || reg_code_i == HCSE_CODE_EVT_RD);
    // Counts active cycles so long holds need no unrolled repetition
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
            run_cnt <= 32'h0;
        else
            run_cnt <= soft_reset_active_o ? run_cnt + 32'h1 : 32'h0;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_read_answer: assert property (rd_take |=> reg_rdata_valid_o) else $error("read not answered");
    a_no_answer: assert property (!rd_take |=> !reg_rdata_valid_o && reg_rdata_o == 32'h0) else $error("spurious read");
    a_cmd_rsvd_zero: assert property (reg_rdata_valid_o && $past(reg_code_i) == HCSE_CODE_CMD_RD
        |-> reg_rdata_o[31:18] == 14'h0 && reg_rdata_o[15:1] == 15'h0) else $error("cmd reserved set");
    a_evt_rsvd_zero: assert property (reg_rdata_valid_o && $past(reg_code_i) == HCSE_CODE_EVT_RD
        |-> reg_rdata_o[31:7] == 25'h0 && !reg_rdata_o[1]) else $error("flag reserved set");
    a_overrun_irq: assert property (sched_overrun_i && !soft_reset_active_o && controller_event_mask_i[0]
        && global_irq_gate_i |=> irq_o) else $error("overrun irq missing");
    a_gate_off_quiet: assert property (!global_irq_gate_i |=> !irq_o) else $error("irq without gate");
    a_mask_off_quiet: assert property (controller_event_mask_i == 7'h00 |=> !irq_o) else $error("irq masked");
    a_reset_starts: assert property (reg_valid_i && reg_code_i == HCSE_CODE_CMD_WR && reg_wdata_i[0]
        && !soft_reset_active_o |=> soft_reset_active_o && suspend_request_o ##1 !suspend_request_o)
        else $error("soft reset start");
    a_reset_length: assert property ($fell(soft_reset_active_o) |-> run_cnt == RESET_HOLD_CYCLES + 1
        && soft_reset_done_o ##1 !soft_reset_done_o) else $error("soft reset length");
    a_reset_bounded: assert property (soft_reset_active_o |-> run_cnt <= RESET_HOLD_CYCLES)
        else $error("soft reset overlong");
endmodule // hcse_cmd_status_regs_sva
bind hcse_cmd_status_regs hcse_cmd_status_regs_sva #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) u_hcse_cmd_status_regs_sva
    (.clk_i, .rst_b_i, .reg_valid_i, .reg_code_i, .reg_wdata_i, .reg_rdata_o, .reg_rdata_valid_o, .sched_overrun_i,
     .controller_event_mask_i, .global_irq_gate_i, .irq_o, .soft_reset_active_o, .suspend_request_o,
     .soft_reset_done_o);

//--- verification/hcse_host_model.sv
`timescale 1ns/1ns
module hcse_host_model
(
    input  wire logic        clk_i,
    output logic             reg_valid_o,
    output logic [7:0]       reg_code_o,
    output logic [31:0]      reg_wdata_o
);
    initial
    begin
        reg_valid_o = 1'b0;
        reg_code_o  = 8'h00;
        reg_wdata_o = 32'h0;
    end
    // Released code and data inverted so stale values never pass as fresh
    task automatic xfer(input logic [7:0] code, input logic [31:0] wdata);
        @(posedge clk_i);
        #1;
        reg_valid_o = 1'b1;
        reg_code_o  = code;
        reg_wdata_o = wdata;
        @(posedge clk_i);
        #1;
        reg_valid_o = 1'b0;
        reg_code_o  = ~code;
        reg_wdata_o = ~wdata;
    endtask
endmodule // hcse_host_model

//--- verification/host_cmd_status_event_regs_tb_top.sv
`timescale 1ns/1ns
module host_cmd_status_event_regs_tb_top
    import hcse_pkg::*;
;
    localparam int HOLD = 4;
    logic        clk_i, rst_b_i, reg_valid, rdata_valid, irq, active, suspend, done;
    logic        ovr, fbeg, fmsb, resume, fatal, root, gate;
    logic [7:0]  reg_code;
    logic [31:0] reg_wdata, rdata;
    logic [6:0]  mask;
    int          err_total, checks_done, cyc, n;
    hcse_host_model u_hcse_host_model (.clk_i(clk_i), .reg_valid_o(reg_valid), .reg_code_o(reg_code),
        .reg_wdata_o(reg_wdata));
    hcse_cmd_status_regs #(.RESET_HOLD_CYCLES(HOLD)) u_hcse_cmd_status_regs (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .reg_valid_i(reg_valid), .reg_code_i(reg_code), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
        .reg_rdata_valid_o(rdata_valid), .sched_overrun_i(ovr), .frame_begin_i(fbeg), .frame_index_msb_i(fmsb),
        .resume_signal_i(resume), .fatal_system_error_i(fatal), .root_port_change_i(root),
        .controller_event_mask_i(mask), .global_irq_gate_i(gate), .irq_o(irq), .soft_reset_active_o(active),
        .suspend_request_o(suspend), .soft_reset_done_o(done));
    task automatic complete_run;
        $display("mismatches %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step;
        @(posedge clk_i);
        #1;
    endtask
    task automatic acc(input logic [7:0] c, input logic [31:0] w);
        u_hcse_host_model.xfer(c, w);
    endtask
    task automatic t_reset_values;
        acc(HCSE_CODE_CMD_RD, 32'h0);
        check("cmd at reset", rdata, 32'h0);
        acc(HCSE_CODE_EVT_RD, 32'h0);
        check("flags at reset", rdata, 32'h0);
        acc(8'h05, 32'hFFFFFFFF);
        check("unknown code answer", {31'h0, rdata_valid}, 32'h0);
        check("unknown code data", rdata, 32'h0);
    endtask
    task automatic t_overrun;
        mask = 7'h01;
        gate = 1'b1;
        ovr = 1'b1;
        repeat (5) step;
        ovr = 1'b0;
        check("overrun irq", {31'h0, irq}, 32'h1);
        mask = 7'h00;
        acc(HCSE_CODE_CMD_RD, 32'h0);
        check("overrun count wrap", rdata, 32'h00010000);
        acc(HCSE_CODE_EVT_RD, 32'h0);
        check("overrun flag", rdata, 32'h1);
        acc(HCSE_CODE_EVT_WR, 32'hFFFFFFFF);
        acc(HCSE_CODE_EVT_RD, 32'h0);
        check("flags cleared", rdata, 32'h0);
    endtask
    task automatic t_events;
        {fbeg, fatal, root, fmsb, resume} = 5'h1F;
        step;
        {fbeg, fatal, root} = 3'h0;
        acc(HCSE_CODE_EVT_RD, 32'h0);
        check("event flags", rdata, 32'h7C);
        acc(HCSE_CODE_EVT_WR, 32'h5C);
        acc(HCSE_CODE_EVT_WR, 32'h0);
        repeat (10) step;
        acc(HCSE_CODE_EVT_RD, 32'h0);
        check("flag kept", rdata, 32'h20);
        acc(HCSE_CODE_EVT_WR, 32'h20);
        fmsb = 1'b0;
        acc(HCSE_CODE_EVT_RD, 32'h0);
        check("wrap on fall", rdata, 32'h20);
    endtask
    task automatic t_irq;
        mask = 7'h20;
        repeat (2) step;
        check("irq on", {31'h0, irq}, 32'h1);
        gate = 1'b0;
        repeat (2) step;
        check("irq gated", {31'h0, irq}, 32'h0);
        gate = 1'b1;
        mask = 7'h5F;
        repeat (2) step;
        check("irq masked", {31'h0, irq}, 32'h0);
    endtask
    task automatic t_soft_reset;
        acc(HCSE_CODE_CMD_WR, 32'hFFFFFFFF);
        check("suspend entry", {30'h0, suspend, active}, 32'h3);
        acc(HCSE_CODE_CMD_WR, 32'h0);
        acc(HCSE_CODE_CMD_RD, 32'h0);
        check("request held", rdata, 32'h1);
        n = 0;
        while (done !== 1'b1 && n < 3 * HOLD)
        begin
            step;
            n++;
        end
        check("reset done", {31'h0, done}, 32'h1);
        acc(HCSE_CODE_CMD_RD, 32'h0);
        check("request cleared", rdata, 32'h0);
        acc(HCSE_CODE_EVT_RD, 32'h0);
        check("flags survive", rdata, 32'h20);
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Ceiling well above the roughly eighty cycles the sequence needs
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            complete_run;
        end
    end
    initial
    begin
        {rst_b_i, ovr, fbeg, fmsb, resume, fatal, root, gate} = 8'h00;
        mask = 7'h00;
        repeat (20) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        repeat (2) step;
        t_reset_values;
        t_overrun;
        t_events;
        t_irq;
        t_soft_reset;
        complete_run;
    end
endmodule // host_cmd_status_event_regs_tb_top

//--- verilog/hcse_cmd_status_regs.sv
`timescale 1ns/1ns
module hcse_cmd_status_regs
    import hcse_pkg::*;
#(
    parameter int RESET_HOLD_CYCLES = HCSE_SOFT_RST_MAX_CYC - HCSE_SOFT_RST_OVERHEAD
)
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   reg_valid_i,
    input  wire logic [7:0]             reg_code_i,
    input  wire logic [31:0]            reg_wdata_i,
    output logic      [31:0]            reg_rdata_o,
    output logic                        reg_rdata_valid_o,
    input  wire logic                   sched_overrun_i,
    input  wire logic                   frame_begin_i,
    input  wire logic                   frame_index_msb_i,
    input  wire logic                   resume_signal_i,
    input  wire logic                   fatal_system_error_i,
    input  wire logic                   root_port_change_i,
    input  wire logic [HCSE_FLAG_W-1:0] controller_event_mask_i,
    input  wire logic                   global_irq_gate_i,
    output logic                        irq_o,
    output logic                        soft_reset_active_o,
    output logic                        suspend_request_o,
    output logic                        soft_reset_done_o
);

    localparam int CNT_W = $clog2(RESET_HOLD_CYCLES + 1);

    initial
    begin
        if (RESET_HOLD_CYCLES < 1)
            $error("Reset hold must be at least one cycle");
        if (RESET_HOLD_CYCLES + HCSE_SOFT_RST_OVERHEAD > HCSE_SOFT_RST_MAX_CYC)
            $error("Software reset would exceed its time limit");
    end

    typedef struct packed
    {
        hcse_rst_state_t rst_state;
        logic [CNT_W-1:0] hold_cnt;
        logic             soft_reset_request;
        logic [1:0]       overrun_cnt;
        logic             frame_msb_prev;
        logic             resume_prev;
        logic             edges_armed;
        logic [31:0]      rdata;
        logic             rdata_valid;
        logic             reset_active;
        logic             suspend_pulse;
        logic             done_pulse;
    } hcse_regs_state_t;

    hcse_regs_state_t         state;
    hcse_regs_state_t         next_state;
    logic [HCSE_FLAG_W-1:0]   flag_set;
    logic [HCSE_FLAG_W-1:0]   flag_clear;
    logic [HCSE_FLAG_W-1:0]   controller_event_flags;
    logic                     flag_irq;
    logic                     cmd_wr;
    logic                     cmd_rd;
    logic                     evt_wr;
    logic                     evt_rd;
    logic                     reset_start;

    function automatic logic code_hit(input logic [7:0] code, input logic [7:0] want);
        code_hit = (code == want);
    endfunction

    function automatic logic [31:0] cmd_word(input logic [1:0] cnt, input logic req);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[HCSE_OVR_CNT_LSB +: HCSE_OVR_CNT_W] = cnt;
        w[HCSE_SOFT_RST_BIT] = req;
        cmd_word = w;
    endfunction

    // Only the four documented codes act; any other code is ignored
    always_comb
    begin
        cmd_rd = reg_valid_i && code_hit(reg_code_i, HCSE_CODE_CMD_RD);
        cmd_wr = reg_valid_i && code_hit(reg_code_i, HCSE_CODE_CMD_WR);
        evt_rd = reg_valid_i && code_hit(reg_code_i, HCSE_CODE_EVT_RD);
        evt_wr = reg_valid_i && code_hit(reg_code_i, HCSE_CODE_EVT_WR);
    end

    // A new request while one runs is absorbed by the set bit
    assign reset_start = cmd_wr && reg_wdata_i[HCSE_SOFT_RST_BIT] && !state.soft_reset_request;

    always_comb
    begin
        flag_set = '0;
        flag_set[HCSE_OVERRUN_BIT]    = sched_overrun_i;
        flag_set[HCSE_FRAME_BEG_BIT]  = frame_begin_i;
        // Edge detectors wait one cycle after reset to avoid a false edge
        flag_set[HCSE_FRAME_WRAP_BIT] = state.edges_armed && (frame_index_msb_i != state.frame_msb_prev);
        // Only the downstream rising edge is watched, so software resume cannot set it
        flag_set[HCSE_RESUME_BIT]     = state.edges_armed && resume_signal_i && !state.resume_prev;
        flag_set[HCSE_FATAL_BIT]      = fatal_system_error_i;
        flag_set[HCSE_ROOT_PORT_BIT]  = root_port_change_i;
        flag_clear = evt_wr ? reg_wdata_i[HCSE_FLAG_W-1:0] : '0;
    end

    always_comb
    begin
        next_state = state;
        next_state.frame_msb_prev = frame_index_msb_i;
        next_state.resume_prev    = resume_signal_i;
        next_state.edges_armed    = 1'b1;
        next_state.suspend_pulse  = 1'b0;
        next_state.done_pulse     = 1'b0;

        // Counter keeps counting whatever the overrun flag holds
        if (sched_overrun_i)
        begin
            next_state.overrun_cnt = state.overrun_cnt + 2'h1;
        end

        unique case (state.rst_state)
            HCSE_RST_IDLE:
            begin
                if (reset_start)
                begin
                    // Write-to-set: only a one starts the reset
                    next_state.soft_reset_request = 1'b1;
                    next_state.rst_state     = HCSE_RST_HOLD;
                    next_state.hold_cnt      = CNT_W'(RESET_HOLD_CYCLES);
                    next_state.reset_active  = 1'b1;
                    next_state.suspend_pulse = 1'b1;
                    // Counter is an operational register and restarts
                    next_state.overrun_cnt   = HCSE_OVR_CNT_RST;
                end
            end
            HCSE_RST_HOLD:
            begin
                // Overruns seen while the engine is held are not counted
                next_state.overrun_cnt = HCSE_OVR_CNT_RST;
                if (state.hold_cnt <= CNT_W'(1))
                begin
                    next_state.rst_state = HCSE_RST_FINISH;
                    next_state.hold_cnt  = '0;
                end
                else
                begin
                    next_state.hold_cnt = state.hold_cnt - CNT_W'(1);
                end
            end
            HCSE_RST_FINISH:
            begin
                // Request bit drops by hardware only, bounded by the hold count
                next_state.soft_reset_request = 1'b0;
                next_state.reset_active       = 1'b0;
                next_state.done_pulse         = 1'b1;
                next_state.rst_state          = HCSE_RST_IDLE;
            end
            default:
            begin
                // Unused code after an upset falls back to idle
                next_state.rst_state = HCSE_RST_IDLE;
            end
        endcase

        // Read data is captured one cycle after the code
        next_state.rdata_valid = cmd_rd || evt_rd;
        if (cmd_rd)
        begin
            next_state.rdata = cmd_word(state.overrun_cnt, state.soft_reset_request);
        end
        else if (evt_rd)
        begin
            next_state.rdata = {25'h0000000, controller_event_flags};
        end
        else
        begin
            next_state.rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state.rst_state          <= HCSE_RST_IDLE;
            state.hold_cnt           <= '0;
            state.soft_reset_request <= HCSE_SOFT_RST_RST;
            state.overrun_cnt        <= HCSE_OVR_CNT_RST;
            state.frame_msb_prev     <= 1'b0;
            state.resume_prev        <= 1'b0;
            state.edges_armed        <= 1'b0;
            state.rdata              <= 32'h0000_0000;
            state.rdata_valid        <= 1'b0;
            state.reset_active       <= 1'b0;
            state.suspend_pulse      <= 1'b0;
            state.done_pulse         <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Flags are not touched by the software reset, so no event is lost
    hcse_event_flags #(
        .FLAG_W (HCSE_FLAG_W)
    ) u_flags (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .set_i   (flag_set),
        .clear_i (flag_clear),
        .mask_i  (controller_event_mask_i),
        .gate_i  (global_irq_gate_i),
        .flags_o (controller_event_flags),
        .irq_o   (flag_irq)
    );

    assign irq_o               = flag_irq;
    assign reg_rdata_o         = state.rdata;
    assign reg_rdata_valid_o   = state.rdata_valid;
    // No root hub or port reset output exists; reset stays inside the engine
    assign soft_reset_active_o = state.reset_active;
    assign suspend_request_o   = state.suspend_pulse;
    assign soft_reset_done_o   = state.done_pulse;

endmodule // hcse_cmd_status_regs

//--- verilog/hcse_event_flags.sv
`timescale 1ns/1ns
module hcse_event_flags
    import hcse_pkg::*;
#(
    parameter int FLAG_W = HCSE_FLAG_W
)
(
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [FLAG_W-1:0] set_i,
    input  wire logic [FLAG_W-1:0] clear_i,
    input  wire logic [FLAG_W-1:0] mask_i,
    input  wire logic              gate_i,
    output logic      [FLAG_W-1:0] flags_o,
    output logic                   irq_o
);

    initial
    begin
        if (FLAG_W != HCSE_FLAG_W)
            $error("Flag width must match the flag layout");
    end

    typedef struct packed
    {
        logic [FLAG_W-1:0] flags;
        logic              irq;
    } hcse_flag_state_t;

    hcse_flag_state_t state;
    hcse_flag_state_t next_state;

    always_comb
    begin
        next_state = state;
        // Set wins over a clear in the same cycle; hardware never clears
        next_state.flags = ((state.flags & ~clear_i) | set_i) & HCSE_FLAG_IMPL;
        // Registered from next flags so irq lines up with the flags
        next_state.irq = gate_i && |(next_state.flags & mask_i);
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state.flags <= HCSE_FLAG_RST;
            state.irq   <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign flags_o = state.flags;
    assign irq_o   = state.irq;

endmodule // hcse_event_flags

//--- verilog/hcse_pkg.sv
package hcse_pkg;

    // Register port access codes; bit 7 marks a write
    localparam logic [7:0] HCSE_CODE_CMD_RD   = 8'h02;
    localparam logic [7:0] HCSE_CODE_CMD_WR   = 8'h82;
    localparam logic [7:0] HCSE_CODE_EVT_RD   = 8'h03;
    localparam logic [7:0] HCSE_CODE_EVT_WR   = 8'h83;
    localparam int         HCSE_CODE_WR_BIT   = 7;

    // Command register fields
    localparam int         HCSE_SOFT_RST_BIT  = 0;
    localparam int         HCSE_OVR_CNT_LSB   = 16;
    localparam int         HCSE_OVR_CNT_W     = 2;
    localparam logic [1:0] HCSE_OVR_CNT_RST   = 2'h0;
    localparam logic       HCSE_SOFT_RST_RST  = 1'b0;

    // Event flag positions
    localparam int         HCSE_FLAG_W        = 7;
    localparam int         HCSE_OVERRUN_BIT   = 0;
    localparam int         HCSE_FRAME_BEG_BIT = 2;
    localparam int         HCSE_RESUME_BIT    = 3;
    localparam int         HCSE_FATAL_BIT     = 4;
    localparam int         HCSE_FRAME_WRAP_BIT = 5;
    localparam int         HCSE_ROOT_PORT_BIT = 6;
    localparam logic [6:0] HCSE_FLAG_IMPL     = 7'h7D;
    localparam logic [6:0] HCSE_FLAG_RST      = 7'h00;

    // Software reset timing
    localparam int         HCSE_CLK_PERIOD_NS = 10;
    localparam int         HCSE_SOFT_RST_MAX_NS = 10000000;
    localparam int         HCSE_SOFT_RST_MAX_CYC = HCSE_SOFT_RST_MAX_NS / HCSE_CLK_PERIOD_NS;
    localparam int         HCSE_SOFT_RST_OVERHEAD = 2;

    typedef enum logic [1:0]
    {
        HCSE_RST_IDLE   = 2'b00,
        HCSE_RST_HOLD   = 2'b01,
        HCSE_RST_FINISH = 2'b11
    } hcse_rst_state_t;

endpackage
